// ---- dwsc_core.sv ----
`timescale 1ns/1ps
`default_nettype none
module dwsc_core #(
  parameter logic [15:0] TOLERANCE_VALUE = 16'h0000
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // serial port
  input wire logic spi_sclk_i,
  input wire logic spi_cs_b_i,
  input wire logic spi_sdi_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_o,
  // control pins
  input wire logic wp_b_i,
  input wire logic preset_restore_pin_b_i,
  // wiper codes
  output logic [9:0] wiper_terminal_one_o,
  output logic [9:0] wiper_terminal_two_o
);

  dwsc_pkg::dwsc_pins_t pins_raw;
  dwsc_pkg::dwsc_pins_t s1_reg;
  dwsc_pkg::dwsc_pins_t s2_reg;
  dwsc_pkg::dwsc_pins_t s3_reg;
  dwsc_pkg::dwsc_pins_t filt_reg;
  dwsc_pkg::dwsc_pins_t filt_q_reg;
  dwsc_pkg::dwsc_frame_t shift_reg;
  dwsc_pkg::dwsc_frame_t exec_frame_reg;
  dwsc_pkg::dwsc_frame_t last_frame_reg;
  dwsc_pkg::dwsc_frame_t out_word;
  logic [4:0] bit_cnt_reg;
  logic exec_reg;
  logic restore_reg;
  logic sdo_reg;
  logic sdo_oe_reg;
  logic [9:0] wiper_register_one_reg;
  logic [9:0] wiper_register_two_reg;
  logic [9:0] wiper_one_next;
  logic [9:0] wiper_two_next;
  logic [15:0] nonvolatile_store_reg [dwsc_pkg::NV_WORDS];
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic preset_fall;
  logic nv_write_ok;

  assign pins_raw = '{sclk: spi_sclk_i, cs_b: spi_cs_b_i, sdi: spi_sdi_i, wp_b: wp_b_i,
                      preset_b: preset_restore_pin_b_i};

  // three-stage synchroniser, a change is accepted once stages two and three agree
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      s1_reg <= dwsc_pkg::PINS_IDLE;
      s2_reg <= dwsc_pkg::PINS_IDLE;
      s3_reg <= dwsc_pkg::PINS_IDLE;
      filt_reg <= dwsc_pkg::PINS_IDLE;
      filt_q_reg <= dwsc_pkg::PINS_IDLE;
    end else begin
      s1_reg <= pins_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= (s3_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));
      filt_q_reg <= filt_reg;
    end
  end

  assign sclk_rise = filt_reg.sclk & ~filt_q_reg.sclk & ~filt_reg.cs_b;
  assign sclk_fall = ~filt_reg.sclk & filt_q_reg.sclk & ~filt_reg.cs_b;
  assign cs_fall = ~filt_reg.cs_b & filt_q_reg.cs_b;
  assign cs_rise = filt_reg.cs_b & ~filt_q_reg.cs_b;
  assign preset_fall = ~filt_reg.preset_b & filt_q_reg.preset_b;
  assign nv_write_ok = filt_reg.wp_b;

  // clock count of the current frame, saturating at one full frame
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      bit_cnt_reg <= dwsc_pkg::CNT_ZERO;
    end else if (cs_fall) begin
      bit_cnt_reg <= dwsc_pkg::CNT_ZERO;
    end else if (sclk_rise && bit_cnt_reg != dwsc_pkg::FRAME_BITS) begin
      bit_cnt_reg <= bit_cnt_reg + dwsc_pkg::CNT_ONE;
    end
  end

  // frame latch on chip-select release; partial frames are dropped
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      exec_reg <= 1'b0;
      exec_frame_reg <= dwsc_pkg::FRAME_NOP;
      last_frame_reg <= dwsc_pkg::FRAME_NOP;
    end else begin
      exec_reg <= 1'b0;
      if (cs_rise && bit_cnt_reg == dwsc_pkg::FRAME_BITS) begin
        // in a chain the last 24 bits clocked in are this device's frame
        exec_reg <= 1'b1;
        exec_frame_reg <= shift_reg;
        last_frame_reg <= shift_reg;
      end else if (cs_rise && bit_cnt_reg == dwsc_pkg::CNT_ZERO) begin
        exec_reg <= 1'b1;
        exec_frame_reg <= last_frame_reg;
      end
    end
  end

  // word to present in the next frame
  always_comb begin
    out_word = exec_frame_reg;
    if (exec_frame_reg.cmd == dwsc_pkg::OP_RD_NV) begin
      out_word.data = nonvolatile_store_reg[exec_frame_reg.addr];
    end else if (exec_frame_reg.cmd == dwsc_pkg::OP_RD_WIPER) begin
      out_word.data = {dwsc_pkg::WIPER_PAD,
                       exec_frame_reg.addr[0] ? wiper_register_two_reg
                                              : wiper_register_one_reg};
    end
  end

  // one register both receives and transmits, so chained devices pass bits on
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      shift_reg <= dwsc_pkg::FRAME_NOP;
    end else if (exec_reg) begin
      shift_reg <= out_word;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[22:0], filt_reg.sdi};
    end
  end

  // data changes on the falling clock so the host samples a settled bit
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      sdo_reg <= 1'b0;
      sdo_oe_reg <= 1'b0;
    end else begin
      sdo_oe_reg <= ~filt_reg.cs_b;
      if (cs_fall || sclk_fall) begin
        sdo_reg <= shift_reg[23];
      end
    end
  end

  // next wiper value for a decoded command
  function automatic logic [9:0] wiper_next(input logic idx, input logic [9:0] code,
                                            input dwsc_pkg::dwsc_frame_t f,
                                            input logic [15:0] saved);
    logic [9:0] r;
    logic hit;
    r = code;
    hit = (f.addr[0] == idx);
    case (f.cmd)
      dwsc_pkg::OP_WRITE: if (hit) r = f.data[9:0];
      dwsc_pkg::OP_RESTORE: if (hit) r = saved[9:0];
      dwsc_pkg::OP_RECALL_ALL: r = saved[9:0];
      dwsc_pkg::OP_RSH, dwsc_pkg::OP_DEC, dwsc_pkg::OP_LSH, dwsc_pkg::OP_INC: begin
        if (hit) r = dwsc_pkg::dwsc_step(code, f.cmd);
      end
      dwsc_pkg::OP_RSH_ALL, dwsc_pkg::OP_DEC_ALL,
      dwsc_pkg::OP_LSH_ALL, dwsc_pkg::OP_INC_ALL: r = dwsc_pkg::dwsc_step(code, f.cmd);
      default: r = code;
    endcase
    return r;
  endfunction : wiper_next

  assign wiper_one_next = wiper_next(1'b0, wiper_register_one_reg, exec_frame_reg,
                                     nonvolatile_store_reg[dwsc_pkg::SAVED_WIPER_ONE]);
  assign wiper_two_next = wiper_next(1'b1, wiper_register_two_reg, exec_frame_reg,
                                     nonvolatile_store_reg[dwsc_pkg::SAVED_WIPER_TWO]);

  // automatic restore request: after reset and on each preset strobe
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      restore_reg <= 1'b1;
    end else begin
      restore_reg <= preset_fall;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      wiper_register_one_reg <= dwsc_pkg::CODE_MID;
      wiper_register_two_reg <= dwsc_pkg::CODE_MID;
    end else if (restore_reg) begin
      wiper_register_one_reg <= nonvolatile_store_reg[dwsc_pkg::SAVED_WIPER_ONE][9:0];
      wiper_register_two_reg <= nonvolatile_store_reg[dwsc_pkg::SAVED_WIPER_TWO][9:0];
    end else if (exec_reg) begin
      wiper_register_one_reg <= wiper_one_next;
      wiper_register_two_reg <= wiper_two_next;
    end
  end

  // nonvolatile words held in flops; reset stands in for the programmed contents
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < dwsc_pkg::NV_WORDS; i++) begin
        nonvolatile_store_reg[i] <= dwsc_pkg::NV_INIT_USER;
      end
      nonvolatile_store_reg[dwsc_pkg::SAVED_WIPER_ONE] <= dwsc_pkg::NV_INIT_WIPER;
      nonvolatile_store_reg[dwsc_pkg::SAVED_WIPER_TWO] <= dwsc_pkg::NV_INIT_WIPER;
      nonvolatile_store_reg[dwsc_pkg::TOLERANCE_WORD] <= TOLERANCE_VALUE;
    end else if (exec_reg && nv_write_ok) begin
      if (exec_frame_reg.cmd == dwsc_pkg::OP_STORE) begin
        nonvolatile_store_reg[{3'b000, exec_frame_reg.addr[0]}] <=
          {dwsc_pkg::WIPER_PAD,
           exec_frame_reg.addr[0] ? wiper_register_two_reg : wiper_register_one_reg};
      end else if (exec_frame_reg.cmd == dwsc_pkg::OP_USER &&
                   exec_frame_reg.addr != dwsc_pkg::TOLERANCE_WORD) begin
        nonvolatile_store_reg[exec_frame_reg.addr] <= exec_frame_reg.data;
      end
    end
  end

  assign spi_sdo_o = sdo_reg;
  assign spi_sdo_oe_o = sdo_oe_reg;
  assign wiper_terminal_one_o = wiper_register_one_reg;
  assign wiper_terminal_two_o = wiper_register_two_reg;

  property p_write_one;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (exec_reg && !restore_reg && exec_frame_reg.cmd == dwsc_pkg::OP_WRITE &&
     exec_frame_reg.addr == 4'h0)
    |=> wiper_terminal_one_o == $past(exec_frame_reg.data[9:0]);
  endproperty
  a_write_one: assert property (p_write_one) else $error("wiper one not written");

  property p_readback_frame;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (exec_reg && exec_frame_reg.cmd != dwsc_pkg::OP_RD_NV &&
     exec_frame_reg.cmd != dwsc_pkg::OP_RD_WIPER)
    |=> shift_reg == $past(exec_frame_reg);
  endproperty
  a_readback_frame: assert property (p_readback_frame) else $error("frame not echoed");

  property p_increment;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (exec_reg && !restore_reg && exec_frame_reg.cmd == dwsc_pkg::OP_INC &&
     exec_frame_reg.addr == 4'h0 && wiper_register_one_reg != dwsc_pkg::CODE_FULL)
    |=> wiper_register_one_reg == $past(wiper_register_one_reg) + dwsc_pkg::CODE_ONE;
  endproperty
  a_increment: assert property (p_increment) else $error("increment wrong");

  property p_protect;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (exec_reg && !filt_reg.wp_b)
    |=> $stable(nonvolatile_store_reg[dwsc_pkg::SAVED_WIPER_ONE]) &&
        $stable(nonvolatile_store_reg[dwsc_pkg::USER_WORD_ONE]);
  endproperty
  a_protect: assert property (p_protect) else $error("protected word changed");

  property p_saturate;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (exec_reg && !restore_reg && exec_frame_reg.cmd == dwsc_pkg::OP_LSH &&
     exec_frame_reg.addr == 4'h0 && wiper_register_one_reg >= dwsc_pkg::CODE_MID)
    |=> wiper_register_one_reg == dwsc_pkg::CODE_FULL;
  endproperty
  a_saturate: assert property (p_saturate) else $error("doubling did not saturate");

  property p_zero_double;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (exec_reg && !restore_reg && exec_frame_reg.cmd == dwsc_pkg::OP_LSH_ALL &&
     wiper_register_two_reg == dwsc_pkg::CODE_ZERO)
    |=> wiper_register_two_reg == dwsc_pkg::CODE_ONE;
  endproperty
  a_zero_double: assert property (p_zero_double) else $error("zero doubling wrong");

  property p_wiper_read;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (exec_reg && exec_frame_reg.cmd == dwsc_pkg::OP_RD_WIPER && exec_frame_reg.addr == 4'h0)
    |=> shift_reg.data == {dwsc_pkg::WIPER_PAD, $past(wiper_register_one_reg)} &&
        shift_reg.cmd == dwsc_pkg::OP_RD_WIPER;
  endproperty
  a_wiper_read: assert property (p_wiper_read) else $error("wiper readback wrong");

  property p_nop;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (exec_reg && !restore_reg && exec_frame_reg.cmd == dwsc_pkg::OP_NOP)
    |=> $stable(wiper_register_one_reg) && $stable(wiper_register_two_reg);
  endproperty
  a_nop: assert property (p_nop) else $error("no-operation changed a wiper");

  property p_preset;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    preset_fall |-> ##2 wiper_register_two_reg ==
                        nonvolatile_store_reg[dwsc_pkg::SAVED_WIPER_TWO][9:0];
  endproperty
  a_preset: assert property (p_preset) else $error("preset restore missed");

  property p_tolerance_ro;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    exec_reg |=> $stable(nonvolatile_store_reg[dwsc_pkg::TOLERANCE_WORD]);
  endproperty
  a_tolerance_ro: assert property (p_tolerance_ro) else $error("tolerance word written");

endmodule : dwsc_core
`default_nettype wire

// ---- dwsc_core_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module dwsc_core_tb;
  typedef struct packed {
    logic chk;
    logic [47:0] sdo;
    logic [9:0] w1;
    logic [9:0] w2;
  } dwsc_note_t;
  // arbitrary factory word
  localparam logic [15:0] TOL = 16'h8a31;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wp_b = 1'b1;
  logic preset_b = 1'b1;
  logic sclk, cs_b, sdi, sdo, oe, done;
  logic [47:0] cap;
  logic [9:0] w1_o, w2_o;
  logic [9:0] w [2];
  logic [15:0] nv [16];
  logic [23:0] prev, last;
  logic [15:0] r;
  logic chk_next;
  dwsc_note_t notes [$];
  integer seed;
  int failures = 0;
  int n_compared = 0;

  always #5 clk = ~clk;

  dwsc_core #(.TOLERANCE_VALUE(TOL)) u_dwsc_core (
    .core_clk_i(clk), .rst_b_i(rst_b), .spi_sclk_i(sclk), .spi_cs_b_i(cs_b),
    .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(oe), .wp_b_i(wp_b),
    .preset_restore_pin_b_i(preset_b), .wiper_terminal_one_o(w1_o),
    .wiper_terminal_two_o(w2_o)
  );
  dwsc_host u_dwsc_host (
    .core_clk_i(clk), .spi_sdo_i(sdo), .spi_sclk_o(sclk), .spi_cs_b_o(cs_b),
    .spi_sdi_o(sdi), .done_o(done), .cap_o(cap)
  );

  task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  function automatic logic [15:0] rnd();
    logic [31:0] v;
    v = $random(seed);
    return v[15:0];
  endfunction : rnd

  function automatic logic [9:0] nstep(input logic [9:0] v, input logic [3:0] c);
    case (c)
      4'h4, 4'h5: return v >> 1;
      4'h6, 4'h7: return (v == 10'h000) ? v : v - 10'h001;
      4'hc, 4'hd: return (v == 10'h000) ? 10'h001 : (v >= 10'h200) ? 10'h3ff : {v[8:0], 1'b0};
      4'he, 4'hf: return (v == 10'h3ff) ? v : v + 10'h001;
      default: return v;
    endcase
  endfunction : nstep

  // reference of one executed frame
  task automatic model(input logic [23:0] f);
    logic [3:0] c;
    logic [3:0] a;
    c = f[23:20];
    a = f[19:16];
    prev = f;
    case (c)
      4'h1: w[a[0]] = nv[a[0]][9:0];
      4'h2: if (wp_b) nv[a[0]] = {6'h00, w[a[0]]};
      4'h3: if (wp_b && a != 4'hf) nv[a] = f[15:0];
      4'h8: for (int k = 0; k < 2; k++) w[k] = nv[k][9:0];
      4'h9: prev = {c, a, nv[a]};
      4'ha: prev = {c, a, 6'h00, w[a[0]]};
      4'hb: w[a[0]] = f[9:0];
      4'h4, 4'h6, 4'hc, 4'he: w[a[0]] = nstep(w[a[0]], c);
      4'h5, 4'h7, 4'hd, 4'hf: for (int k = 0; k < 2; k++) w[k] = nstep(w[k], c);
      default: ;
    endcase
  endtask : model

  task automatic run(input logic [47:0] bits, input int n);
    dwsc_note_t nt;
    nt.chk = chk_next && n > 0;
    // a long frame passes its first half straight through
    nt.sdo = (n == 48) ? {prev, bits[47:24]} : {24'h0, prev};
    if (n > 0) last = bits[23:0];
    model(last);
    chk_next = 1'b1;
    nt.w1 = w[0];
    nt.w2 = w[1];
    notes.push_back(nt);
    u_dwsc_host.send(bits, n);
  endtask : run

  task automatic fr(input logic [23:0] f);
    run({24'h0, f}, 24);
  endtask : fr

  task automatic pulse_preset();
    preset_b <= 1'b0;
    repeat (4) @(posedge clk);
    preset_b <= 1'b1;
    repeat (12) @(posedge clk);
    w[0] = nv[0][9:0];
    w[1] = nv[1][9:0];
  endtask : pulse_preset

  task automatic tell(input string s);
    $display("test %s finished", s);
  endtask : tell

  always @(posedge clk) begin
    dwsc_note_t nt;
    // the output is only driven while selected; sclk is high only inside a frame
    if (sclk === 1'b1) check({47'h0, oe}, 48'h1, "output enable");
    if (done === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      if (nt.chk) check(cap, nt.sdo, "serial out");
      check({38'h0, w1_o}, {38'h0, nt.w1}, "wiper one");
      check({38'h0, w2_o}, {38'h0, nt.w2}, "wiper two");
      check({47'h0, oe}, 48'h0, "output enable idle");
    end
  end

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    $display("BAD at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    seed = 32'h96ff2997;
    for (int k = 0; k < 16; k++) nv[k] = (k < 2) ? 16'h0200 : 16'h0000;
    nv[15] = TOL;
    w[0] = 10'h200;
    w[1] = 10'h200;
    prev = '0;
    last = '0;
    chk_next = 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge clk);
    fr({8'h00, rnd()});
    tell("power-on");
    fr(24'hb00100);
    fr(24'hb10200);
    fr({8'he0, rnd()});
    fr({8'he0, rnd()});
    tell("write and step");
    fr(24'h200000);
    fr(24'hb00000);
    fr({8'hc0, rnd()});
    fr(24'h100000);
    tell("store and restore");
    wp_b <= 1'b0;
    @(posedge clk);
    fr(24'hb00155);
    fr(24'h200000);
    fr(24'h321111);
    fr(24'h100000);
    fr(24'h920000);
    wp_b <= 1'b1;
    @(posedge clk);
    tell("protect");
    fr(24'hb00100);
    fr({8'hc0, rnd()});
    fr({8'hc0, rnd()});
    fr({8'hc1, rnd()});
    fr({8'ha0, rnd()});
    fr({8'ha1, rnd()});
    tell("double and read wiper");
    fr(24'h32aaaa);
    fr(24'h335555);
    fr(24'h920000);
    fr(24'h930000);
    fr(24'h3f1234);
    fr(24'h9f0000);
    fr(24'h000000);
    tell("user words");
    fr(24'hb00005);
    fr(24'hb103fe);
    fr({8'hf0, rnd()});
    fr({8'hf0, rnd()});
    fr({8'h70, rnd()});
    fr({8'hd0, rnd()});
    fr({8'h50, rnd()});
    // wiper two at zero so the both-wiper doubling must give code one
    fr(24'hb10000);
    fr({8'hd0, rnd()});
    fr({8'h40, rnd()});
    fr({8'h61, rnd()});
    fr(24'h210000);
    fr(24'h800000);
    fr({8'he1, rnd()});
    fr(24'h110000);
    tell("both wipers");
    fr({8'he0, rnd()});
    run('0, 0);
    fr(24'h000000);
    tell("strobe repeat");
    fr(24'hb00123);
    fr(24'h200000);
    fr(24'hb00077);
    fr(24'hb10011);
    pulse_preset();
    fr(24'h000000);
    tell("preset");
    r = rnd();
    run({8'hb1, rnd(), 8'hb0, 6'h00, r[9:0]}, 48);
    fr(24'h000000);
    tell("chain");
    repeat (6) begin
      r = rnd();
      fr({4'hb, 3'h0, r[10], 6'h00, r[9:0]});
      fr({4'ha, 3'h0, r[10], rnd()});
      fr({8'h00, rnd()});
    end
    tell("random");
    wrap_up();
  end
endmodule : dwsc_core_tb
`default_nettype wire

// ---- dwsc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// host controller model: mode 0, msb first, clocked slowly enough for the pin synchronisers
module dwsc_host (
  // clock
  input wire logic core_clk_i,
  // serial port
  input wire logic spi_sdo_i,
  output logic spi_sclk_o,
  output logic spi_cs_b_o,
  output logic spi_sdi_o,
  // capture
  output logic done_o,
  output logic [47:0] cap_o
);
  localparam int HALF = 10;

  initial begin
    spi_sclk_o = 1'b0;
    spi_cs_b_o = 1'b1;
    spi_sdi_o = 1'b0;
    done_o = 1'b0;
    cap_o = '0;
  end

  // entered at a rising edge; n = 0 gives a bare chip-select strobe
  task automatic send(input logic [47:0] bits, input int n);
    int i;
    cap_o <= '0;
    spi_cs_b_o <= 1'b0;
    repeat (HALF) @(posedge core_clk_i);
    for (i = 0; i < n; i++) begin
      spi_sdi_o <= bits[n - 1 - i];
      repeat (HALF) @(posedge core_clk_i);
      spi_sclk_o <= 1'b1;
      cap_o <= {cap_o[46:0], spi_sdo_i};
      repeat (HALF) @(posedge core_clk_i);
      spi_sclk_o <= 1'b0;
    end
    repeat (HALF) @(posedge core_clk_i);
    spi_cs_b_o <= 1'b1;
    // deselected data line toggles so a stale bit can never look valid
    repeat (2 * HALF) begin
      @(posedge core_clk_i);
      spi_sdi_o <= ~spi_sdi_o;
    end
    done_o <= 1'b1;
    @(posedge core_clk_i);
    done_o <= 1'b0;
  endtask : send
endmodule : dwsc_host
`default_nettype wire

// ---- dwsc_pkg.sv ----
`default_nettype none
package dwsc_pkg;

  // serial frame: command nibble, address nibble, data field, msb first
  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [15:0] data;
  } dwsc_frame_t;

  // synchronised pin group
  typedef struct packed {
    logic sclk;
    logic cs_b;
    logic sdi;
    logic wp_b;
    logic preset_b;
  } dwsc_pins_t;

  localparam dwsc_pins_t PINS_IDLE = '{sclk: 1'b0, cs_b: 1'b1, sdi: 1'b0, wp_b: 1'b1,
                                       preset_b: 1'b1};
  localparam dwsc_frame_t FRAME_NOP = '{cmd: 4'h0, addr: 4'h0, data: 16'h0000};

  localparam logic [4:0] FRAME_BITS = 5'h18;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_ONE = 5'h01;

  // commands
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_RESTORE = 4'h1;
  localparam logic [3:0] OP_STORE = 4'h2;
  localparam logic [3:0] OP_USER = 4'h3;
  localparam logic [3:0] OP_RSH = 4'h4;
  localparam logic [3:0] OP_RSH_ALL = 4'h5;
  localparam logic [3:0] OP_DEC = 4'h6;
  localparam logic [3:0] OP_DEC_ALL = 4'h7;
  localparam logic [3:0] OP_RECALL_ALL = 4'h8;
  localparam logic [3:0] OP_RD_NV = 4'h9;
  localparam logic [3:0] OP_RD_WIPER = 4'ha;
  localparam logic [3:0] OP_WRITE = 4'hb;
  localparam logic [3:0] OP_LSH = 4'hc;
  localparam logic [3:0] OP_LSH_ALL = 4'hd;
  localparam logic [3:0] OP_INC = 4'he;
  localparam logic [3:0] OP_INC_ALL = 4'hf;

  // wiper codes
  localparam logic [9:0] CODE_ZERO = 10'h000;
  localparam logic [9:0] CODE_ONE = 10'h001;
  localparam logic [9:0] CODE_MID = 10'h200;
  localparam logic [9:0] CODE_FULL = 10'h3ff;
  localparam logic [5:0] WIPER_PAD = 6'h00;

  // nonvolatile map
  localparam int NV_WORDS = 16;
  localparam logic [3:0] SAVED_WIPER_ONE = 4'h0;
  localparam logic [3:0] SAVED_WIPER_TWO = 4'h1;
  localparam logic [3:0] USER_WORD_ONE = 4'h2;
  localparam logic [3:0] USER_WORD_TWO = 4'h3;
  localparam logic [3:0] TOLERANCE_WORD = 4'hf;
  localparam logic [15:0] NV_INIT_WIPER = 16'h0200;
  localparam logic [15:0] NV_INIT_USER = 16'h0000;

  // one step of the relative commands on a 10-bit wiper code
  function automatic logic [9:0] dwsc_step(input logic [9:0] code, input logic [3:0] op);
    logic [9:0] r;
    r = code;
    case (op)
      OP_RSH, OP_RSH_ALL: r = code >> 1;
      OP_DEC, OP_DEC_ALL: begin
        if (code != CODE_ZERO) r = code - CODE_ONE;
      end
      OP_LSH, OP_LSH_ALL: begin
        // saturating doubling keeps the log taper monotonic
        if (code == CODE_ZERO) r = CODE_ONE;
        else if (code >= CODE_MID) r = CODE_FULL;
        else r = {code[8:0], 1'b0};
      end
      OP_INC, OP_INC_ALL: begin
        if (code != CODE_FULL) r = code + CODE_ONE;
      end
      default: r = code;
    endcase
    return r;
  endfunction : dwsc_step

endpackage : dwsc_pkg
`default_nettype wire
